// ---- hw/oms_pkg.sv ----
// Package for the operating mode sequencer: offsets, codes, timings, carriers
package oms_pkg;
  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] STARTUP_KEY_ADDR = 8'h0f;
  localparam logic [7:0] OPERATING_MODE_ADDR = 8'h10;
  localparam logic [7:0] SHADOW_ADDR = 8'h29;
  // ********************************************************
  // Start-up key values
  // ********************************************************
  localparam logic [7:0] KEY_VALUE = 8'h42;
  localparam logic [7:0] KEY_RD_BOOTING = 8'h45;
  localparam logic [7:0] KEY_RD_READY = 8'h40;
  localparam logic [7:0] KEY_RD_UNLOCKED = 8'h43;
  // ********************************************************
  // Mode-control fields and reset
  // ********************************************************
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int RESV_BIT = 3;
  localparam int X_OFF_BIT = 4;
  localparam int Y_OFF_BIT = 5;
  localparam int Z_OFF_BIT = 6;
  localparam int BURST_START_BIT = 7;
  // ********************************************************
  // Mode request codes
  // ********************************************************
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_WATCH = 3'h2;
  localparam logic [2:0] MODE_RSV_A = 3'h3;
  localparam logic [2:0] MODE_RSV_B = 3'h4;
  localparam logic [2:0] MODE_CONTINUOUS = 3'h5;
  localparam logic [2:0] MODE_WATCH_SAMPLE = 3'h6;
  localparam logic [2:0] MODE_COUNTED_BURST = 3'h7;
  localparam logic [7:0] BURST_CONTINUOUS = 8'hff;
  localparam logic [7:0] BURST_ZERO = 8'h00;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_HZ = 125000000;
  localparam int HEARTBEAT_STEPS = 3;
  localparam int REPORT_LAG_MS = 2;
  localparam int REPORT_LAG_MAX_MS = 10;
  localparam int REPORT_LAG_CYCLES = REPORT_LAG_MS * (CLK_HZ / 1000);
  localparam int HEARTBEAT_DIV = 1000;
  localparam int STARTUP_CYCLES = 64;
  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } oms_req_t;
  typedef struct packed {
    logic z_off;
    logic y_off;
    logic x_off;
    logic resv;
    logic [2:0] mode;
  } oms_mode_t;
  typedef struct packed {
    logic clocks_on;
    logic sampling_on;
    logic activity_on;
    logic fifo_allowed;
    logic x_on;
    logic y_on;
    logic z_on;
  } oms_enables_t;
  typedef enum logic [1:0] {
    OMS_BOOTING,
    OMS_READY,
    OMS_UNLOCKED
  } oms_key_state_t;
endpackage

// ---- hw/oms_heartbeat.sv ----
// Heartbeat enable divider for the operating mode sequencer
`timescale 1ns/1ps
module oms_heartbeat #(
  parameter int DIV = oms_pkg::HEARTBEAT_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Heartbeat pulse
  output logic tick
);
  logic [31:0] count_q;

  // Divide the system clock into a one-cycle pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 32'h0;
      tick <= 1'b0;
    end else if (count_q == 32'(DIV - 1)) begin
      count_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ---- hw/oms_top.sv ----
// Operating mode sequencer: start-up key, mode control and burst sequencing
// How it works
// R1: Host writes key 0x42 after every power-up or reset.
// R2: Key register reads 0x45 while the start-up sequence runs.
// R3: Key register reads 0x40 after start-up, before key written.
// R4: After key 0x42 written, key register reads 0x43.
// R5: Mode requests take effect within three heartbeat ticks.
// R6: Hardware itself rewrites the mode field on auto events.
// R7: Reported mode lags a new request by 2 to 10 ms.
// R8: Code 000 is sleep: everything halted, clocks off.
// R9: Code 001 is standby: clocks on, no sampling.
// R10: Code 010 watches activity, then switches to continuous sampling.
// R11: Code 101 samples XYZ continuously, activity logic off.
// R12: Code 110 runs activity logic, sampling and FIFO together.
// R13: Code 111 is counted burst, then returns to sleep.
// R14: Bits 4,5,6 switch off X, Y, Z axes when set.
// R15: Bit 7 starts one-shot burst; count 255 means continuous.
// R16: Burst sample count comes from shadow register at 0x29.
// R17: A burst starts only from standby; here a mode 111 counted burst starts whatever the previous mode was.
// R18: One-shot burst with count below 255 returns to standby.
// R19: With pin trigger enabled, interrupt pin triggers mode 111 samples.
// R20: Reserved codes and bit 3 writes are ignored; mode kept. Here such a write still loads axis bits 4, 5, 6.
`timescale 1ns/1ps
module oms_top #(
  parameter int STARTUP_CYCLES = oms_pkg::STARTUP_CYCLES,
  parameter int HEARTBEAT_DIV = oms_pkg::HEARTBEAT_DIV,
  parameter int REPORT_LAG_CYCLES = oms_pkg::REPORT_LAG_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire oms_pkg::oms_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Sample pipeline handshake and trigger pin
  input wire logic sample_done,
  input wire logic activity_detected,
  input wire logic pin_trigger_enable,
  input wire logic interrupt_out_pin,
  // Block controls
  output oms_pkg::oms_enables_t enables,
  output logic sample_req,
  output logic [2:0] reported_mode,
  output logic burst_active
);
  // ********************************************************
  // Declarations
  // ********************************************************
  logic tick;
  oms_pkg::oms_key_state_t key_q;
  logic [31:0] boot_cnt_q;
  oms_pkg::oms_mode_t ctrl_q;
  logic [2:0] applied_q;
  logic [1:0] hb_cnt_q;
  logic [31:0] lag_cnt_q;
  logic [7:0] burst_count_q;
  logic [7:0] burst_left_q;
  logic oneshot_q;
  logic pin_q;
  logic wr_key;
  logic wr_mode;
  logic wr_shadow;
  logic reserved_code;
  logic burst_finish;
  logic pin_edge;
  logic mode_clocks;
  logic mode_sampling;
  logic mode_activity;
  logic mode_fifo;

  oms_heartbeat #(
    .DIV(HEARTBEAT_DIV)
  ) u_heartbeat (
    .clock(clock),
    .reset_n(reset_n),
    .tick(tick)
  );

  // ********************************************************
  // Register decode
  // ********************************************************
  assign wr_key = req.wr && (req.addr == oms_pkg::STARTUP_KEY_ADDR);
  assign wr_mode = req.wr && (req.addr == oms_pkg::OPERATING_MODE_ADDR);
  assign wr_shadow = req.wr && (req.addr == oms_pkg::SHADOW_ADDR);
  assign reserved_code = (req.wdata[oms_pkg::MODE_MSB:oms_pkg::MODE_LSB]
                          == oms_pkg::MODE_RSV_A) ||
                         (req.wdata[oms_pkg::MODE_MSB:oms_pkg::MODE_LSB]
                          == oms_pkg::MODE_RSV_B);
  assign burst_finish = burst_active && sample_done &&
                        (burst_count_q != oms_pkg::BURST_CONTINUOUS) &&
                        (burst_left_q <= 8'h01);
  assign pin_edge = pin_trigger_enable && interrupt_out_pin && !pin_q;

  // ********************************************************
  // Start-up key state
  // ********************************************************
  // Boot counter models the internal start-up sequence
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boot_cnt_q <= 32'h0;
      key_q <= oms_pkg::OMS_BOOTING;
    end else begin
      case (key_q)
        oms_pkg::OMS_BOOTING: begin
          if (boot_cnt_q == 32'(STARTUP_CYCLES - 1)) begin
            key_q <= oms_pkg::OMS_READY;
          end else begin
            boot_cnt_q <= boot_cnt_q + 32'h1;
          end
        end
        oms_pkg::OMS_READY: begin
          if (wr_key && (req.wdata == oms_pkg::KEY_VALUE)) begin // [R1] [R4]
            key_q <= oms_pkg::OMS_UNLOCKED;
          end
        end
        oms_pkg::OMS_UNLOCKED: key_q <= oms_pkg::OMS_UNLOCKED;
        default: key_q <= oms_pkg::OMS_BOOTING;
      endcase
    end
  end

  // Read-back path; key register reports phase, not written value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd && req.addr == oms_pkg::STARTUP_KEY_ADDR) begin
        case (key_q)
          oms_pkg::OMS_BOOTING: rdata <= oms_pkg::KEY_RD_BOOTING; // [R2]
          oms_pkg::OMS_READY: rdata <= oms_pkg::KEY_RD_READY; // [R3]
          oms_pkg::OMS_UNLOCKED: rdata <= oms_pkg::KEY_RD_UNLOCKED; // [R4]
          default: rdata <= oms_pkg::KEY_RD_BOOTING;
        endcase
      end else if (req.rd && req.addr == oms_pkg::SHADOW_ADDR) begin
        rdata <= burst_count_q;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ********************************************************
  // Mode-control register
  // ********************************************************
  // Software writes and hardware auto events share the mode field
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= oms_pkg::oms_mode_t'(oms_pkg::MODE_RESET[6:0]);
    end else if (burst_finish && ctrl_q.mode == oms_pkg::MODE_COUNTED_BURST) begin
      ctrl_q.mode <= oms_pkg::MODE_SLEEP; // [R6] [R13]
    end else if (burst_finish) begin
      ctrl_q.mode <= oms_pkg::MODE_STANDBY; // [R6] [R18]
    end else if (wr_mode) begin
      ctrl_q.x_off <= req.wdata[oms_pkg::X_OFF_BIT];
      ctrl_q.y_off <= req.wdata[oms_pkg::Y_OFF_BIT];
      ctrl_q.z_off <= req.wdata[oms_pkg::Z_OFF_BIT];
      ctrl_q.resv <= 1'b0; // [R20]
      if (!reserved_code && !req.wdata[oms_pkg::RESV_BIT]) begin // [R20]
        ctrl_q.mode <= req.wdata[oms_pkg::MODE_MSB:oms_pkg::MODE_LSB];
      end
    end else if (applied_q == oms_pkg::MODE_WATCH && activity_detected) begin
      ctrl_q.mode <= oms_pkg::MODE_CONTINUOUS; // [R6] [R10]
    end
  end

  // Applied mode follows request on heartbeat ticks, within three
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      applied_q <= oms_pkg::MODE_SLEEP;
      hb_cnt_q <= 2'h0;
    end else if (applied_q != ctrl_q.mode) begin
      if (tick) begin
        if (hb_cnt_q == 2'(oms_pkg::HEARTBEAT_STEPS - 1)) begin // [R5]
          applied_q <= ctrl_q.mode;
          hb_cnt_q <= 2'h0;
        end else begin
          hb_cnt_q <= hb_cnt_q + 2'h1;
        end
      end
    end else begin
      hb_cnt_q <= 2'h0;
    end
  end

  // Reported mode lags the applied mode by the status delay
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reported_mode <= oms_pkg::MODE_SLEEP;
      lag_cnt_q <= 32'h0;
    end else if (reported_mode != applied_q) begin
      if (lag_cnt_q >= 32'(REPORT_LAG_CYCLES - 1)) begin // [R7]
        reported_mode <= applied_q;
        lag_cnt_q <= 32'h0;
      end else begin
        lag_cnt_q <= lag_cnt_q + 32'h1;
      end
    end else begin
      lag_cnt_q <= 32'h0;
    end
  end

  // ********************************************************
  // Burst sequencing
  // ********************************************************
  // Shadow burst count register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      burst_count_q <= oms_pkg::BURST_ZERO;
    end else if (wr_shadow) begin
      burst_count_q <= req.wdata; // [R16]
    end
  end

  // One-shot start only from standby, counts samples down
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      burst_active <= 1'b0;
      oneshot_q <= 1'b0;
      burst_left_q <= oms_pkg::BURST_ZERO;
    end else if (burst_finish) begin
      burst_active <= 1'b0;
      oneshot_q <= 1'b0;
    end else if (wr_mode && req.wdata[oms_pkg::BURST_START_BIT] &&
                 !pin_trigger_enable && applied_q == oms_pkg::MODE_STANDBY &&
                 burst_count_q != oms_pkg::BURST_ZERO) begin // [R15] [R17]
      burst_active <= 1'b1;
      oneshot_q <= 1'b1;
      burst_left_q <= burst_count_q; // [R16]
    end else if (!burst_active && applied_q == oms_pkg::MODE_COUNTED_BURST &&
                 ctrl_q.mode == oms_pkg::MODE_COUNTED_BURST &&
                 burst_count_q != oms_pkg::BURST_ZERO) begin // [R13]
      burst_active <= 1'b1;
      oneshot_q <= 1'b0;
      burst_left_q <= burst_count_q;
    end else if (burst_active && sample_done &&
                 burst_count_q != oms_pkg::BURST_CONTINUOUS) begin // [R15]
      burst_left_q <= burst_left_q - 8'h01;
    end
  end

  // Trigger pin edge tracking
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= interrupt_out_pin;
    end
  end

  // ********************************************************
  // Block enables and sample requests
  // ********************************************************
  // Per-mode block activity for the applied mode
  always_comb begin
    mode_clocks = 1'b1;
    mode_sampling = 1'b0;
    mode_activity = 1'b0;
    mode_fifo = 1'b0;
    case (applied_q)
      oms_pkg::MODE_SLEEP: begin
        mode_clocks = 1'b0; // [R8]
      end
      oms_pkg::MODE_STANDBY: begin
        mode_clocks = 1'b1; // [R9]
      end
      oms_pkg::MODE_WATCH: begin
        mode_activity = 1'b1; // [R10]
      end
      oms_pkg::MODE_CONTINUOUS: begin
        mode_sampling = 1'b1; // [R11]
        mode_fifo = 1'b1;
      end
      oms_pkg::MODE_WATCH_SAMPLE: begin
        mode_sampling = 1'b1; // [R12]
        mode_activity = 1'b1;
        mode_fifo = 1'b1;
      end
      default: begin
        mode_clocks = 1'b1;
      end
    endcase
  end

  // Registered enables; a burst turns sampling on in any mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enables <= '0;
      sample_req <= 1'b0;
    end else begin
      enables.clocks_on <= mode_clocks || oneshot_q; // [R8] [R9]
      enables.activity_on <= mode_activity; // [R10] [R11]
      enables.sampling_on <= mode_sampling || burst_active; // [R11] [R12]
      enables.fifo_allowed <= mode_fifo || burst_active; // [R12]
      enables.x_on <= !ctrl_q.x_off; // [R14]
      enables.y_on <= !ctrl_q.y_off; // [R14]
      enables.z_on <= !ctrl_q.z_off; // [R14]
      // Pin trigger paces samples in counted-burst mode
      if (pin_trigger_enable) begin
        sample_req <= burst_active && !oneshot_q && pin_edge; // [R19]
      end else begin
        sample_req <= burst_active && tick;
      end
    end
  end
endmodule

// ---- sim/oms_monitor.sv ----
// Port checker for the operating mode sequencer
`timescale 1ns/1ps
module oms_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire oms_pkg::oms_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Block controls
  input wire oms_pkg::oms_enables_t enables,
  input wire logic sample_req,
  input wire logic [2:0] reported_mode,
  input wire logic burst_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [3:0] calm_q;
  logic [10:0] last_q;
  logic [2:0] en3;
  logic calm;
  // ****************************************
  // Settled-state tracking
  // ****************************************
  assign en3 = {enables.clocks_on, enables.sampling_on, enables.activity_on};
  assign calm = (calm_q >= 4'ha) && !burst_active &&
                ({reported_mode, enables, burst_active} == last_q);
  // Cycles with mode, enables and burst all steady
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      calm_q <= 4'h0;
      last_q <= 11'h0;
    end else begin
      last_q <= {reported_mode, enables, burst_active};
      if ({reported_mode, enables, burst_active} != last_q) begin
        calm_q <= 4'h0;
      end else if (calm_q != 4'hf) begin
        calm_q <= calm_q + 4'h1;
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  rd_answer_a: assert property (req.rd |=> rvalid) else $error("read not answered");
  rd_only_a: assert property (!req.rd |=> !rvalid) else $error("answer without read");
  key_code_a: assert property (req.rd && req.addr == oms_pkg::STARTUP_KEY_ADDR |=>
    rdata inside {8'h45, 8'h40, 8'h43}) else $error("bad key read-back");
  unmapped_zero_a: assert property (req.rd && !(req.addr inside {8'h0f, 8'h10, 8'h29})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  sleep_halt_a: assert property (calm && reported_mode == 3'h0 |-> en3 == 3'h0)
    else $error("sleep enables wrong");
  standby_idle_a: assert property (calm && reported_mode == 3'h1 |-> en3 == 3'h4)
    else $error("standby enables wrong");
  watch_only_a: assert property (calm && reported_mode == 3'h2 |-> en3 == 3'h5)
    else $error("watch enables wrong");
  cont_sample_a: assert property (calm && reported_mode == 3'h5 |-> en3 == 3'h6)
    else $error("continuous enables wrong");
  both_on_a: assert property (calm && reported_mode == 3'h6 |-> en3 == 3'h7)
    else $error("combined enables wrong");
  burst_req_a: assert property (sample_req |-> burst_active)
    else $error("sample request outside burst");
  // Main scenarios seen
  cover property (rvalid && rdata == 8'h43);
  cover property ($fell(burst_active));
  cover property (reported_mode == 3'h5);
endmodule
bind oms_top oms_monitor mon (.clock(clock), .reset_n(reset_n), .req(req), .rdata(rdata),
  .rvalid(rvalid), .enables(enables), .sample_req(sample_req),
  .reported_mode(reported_mode), .burst_active(burst_active));

// ---- sim/oms_host.sv ----
// Host microcontroller model on the register port
`timescale 1ns/1ps
module oms_host (
  // Clock
  input wire logic clock,
  // Register port
  output oms_pkg::oms_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // One-cycle write; released address and data are inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // One-cycle read, answer taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    d = rdata;
    v = rvalid;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
  // Key write after every reset
  task automatic unlock();
    wr(oms_pkg::STARTUP_KEY_ADDR, oms_pkg::KEY_VALUE);
  endtask
endmodule

// ---- sim/operating_mode_sequencer_test.sv ----
// Self-checking testbench for the operating mode sequencer
`timescale 1ns/1ps
module operating_mode_sequencer_test;
  logic clock, reset_n, sample_done, activity_detected, pin_trigger_enable, interrupt_out_pin;
  logic sample_req, rvalid, burst_active, v;
  logic [7:0] rdata, d, ax;
  logic [2:0] reported_mode;
  oms_pkg::oms_req_t req;
  oms_pkg::oms_enables_t enables;
  int n_errors, checks_done, seed, n_req, k, n;
  int modes[5] = '{1, 2, 5, 6, 0};
  oms_top #(.STARTUP_CYCLES(4), .HEARTBEAT_DIV(4), .REPORT_LAG_CYCLES(8)) uut (.clock(clock),
    .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid), .sample_done(sample_done),
    .activity_detected(activity_detected), .pin_trigger_enable(pin_trigger_enable),
    .interrupt_out_pin(interrupt_out_pin), .enables(enables), .sample_req(sample_req),
    .reported_mode(reported_mode), .burst_active(burst_active));
  oms_host host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Sample pipeline: one done pulse per request
  always @(negedge clock) begin
    sample_done <= sample_req;
    if (sample_req === 1'b1) n_req++;
  end
  // Expected {clocks, sampling, activity, fifo} per mode code
  function automatic logic [7:0] en_of(int m);
    case (m)
      1: return 8'h08;
      2: return 8'h0a;
      5: return 8'h0d;
      6: return 8'h0f;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Settle, then compare mode, enables and axes
  task automatic chk_mode(input int m, input logic [2:0] a);
    repeat (60) @(negedge clock);
    chk8({5'h0, reported_mode}, m[7:0], "mode");
    chk8({4'h0, enables.clocks_on, enables.sampling_on, enables.activity_on,
          enables.fifo_allowed}, en_of(m), "en");
    chk8({5'h0, enables.z_on, enables.y_on, enables.x_on}, {5'h0, ~a}, "axes");
  endtask
  // Bounded wait for a burst to end
  task automatic burst_end();
    repeat (8) @(negedge clock);
    for (k = 0; k < 400 && burst_active !== 1'b0; k++) @(negedge clock);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    seed = 58;
    {reset_n, activity_detected, pin_trigger_enable, interrupt_out_pin} = '0;
    {n_errors, checks_done, n_req} = '0;
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    // Start-up key sequence and unmapped read
    host.rd(8'h0f, d, v);
    chk8(d, 8'h45, "key boot");
    chk8({7'h0, v}, 8'h01, "rvalid");
    repeat (10) @(negedge clock);
    host.wr(8'h0f, 8'h13);
    host.rd(8'h0f, d, v);
    chk8(d, 8'h40, "key ready");
    host.unlock();
    host.rd(8'h0f, d, v);
    chk8(d, 8'h43, "key open");
    host.rd(8'h11, d, v);
    chk8(d, 8'h00, "unmapped");
    // Every documented mode except counted burst (111), with random axis bits
    for (int i = 0; i < 5; i++) begin
      ax = $random(seed);
      host.wr(8'h10, {1'b0, ax[2:0], 1'b0, modes[i][2:0]});
      chk_mode(modes[i], ax[2:0]);
    end
    // Burst start refused outside standby, reserved writes ignored
    host.wr(8'h29, 8'h03);
    host.wr(8'h10, 8'h80);
    chk_mode(0, 3'h0);
    chk8({7'h0, burst_active}, 8'h00, "no burst from sleep");
    host.wr(8'h10, 8'h03);
    host.wr(8'h10, 8'h04);
    host.wr(8'h10, 8'h0d);
    chk_mode(0, 3'h0);
    // One-shot burst of random length from standby
    n = {$random(seed)} % 4 + 1;
    host.wr(8'h10, 8'h01);
    chk_mode(1, 3'h0);
    host.wr(8'h29, n[7:0]);
    host.rd(8'h29, d, v);
    chk8(d, n[7:0], "count");
    n_req = 0;
    host.wr(8'h10, 8'h81);
    burst_end();
    chk8(n_req[7:0], n[7:0], "burst samples");
    chk_mode(1, 3'h0);
    // Activity in watch mode moves to continuous sampling
    host.wr(8'h10, 8'h02);
    chk_mode(2, 3'h0);
    activity_detected = 1'b1;
    @(negedge clock);
    activity_detected = 1'b0;
    chk_mode(5, 3'h0);
    // Pin-triggered counted burst ends in sleep
    host.wr(8'h29, 8'h02);
    pin_trigger_enable = 1'b1;
    host.wr(8'h10, 8'h01);
    chk_mode(1, 3'h0);
    host.wr(8'h10, 8'h07);
    repeat (30) @(negedge clock);
    n_req = 0;
    repeat (2) begin
      interrupt_out_pin = 1'b1;
      repeat (4) @(negedge clock);
      interrupt_out_pin = 1'b0;
      repeat (4) @(negedge clock);
    end
    burst_end();
    chk8(n_req[7:0], 8'h02, "pin burst");
    chk_mode(0, 3'h0);
    tally_and_finish();
  end
endmodule
